//--- v86_dispatch_pkg.sv
package v86_dispatch_pkg;

    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] FLAGS_OFS   = 8'h04;
    localparam logic [7:0] ISTAT_OFS   = 8'h08;
    localparam logic [7:0] ICLR_OFS    = 8'h0c;
    localparam logic [7:0] IEN_OFS     = 8'h10;
    localparam logic [7:0] LAST_OFS    = 8'h14;
    localparam logic [7:0] REDIR_BASE  = 8'h40;
    localparam logic [7:0] IOPM_BASE   = 8'h80;
    localparam int         REDIR_WORDS = 8;
    localparam int         IOPM_WORDS  = 32;
    localparam logic [16:0] IOPM_PORTS = 17'h00400;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int          CTRL_VME_BIT = 0;
    localparam int          CTRL_PL_LSB  = 4;
    localparam int          FL_IO_PRIVILEGE_LEVEL_LSB  = 12;
    localparam int          FL_VM_BIT    = 17;
    localparam int          FL_VIF_BIT   = 19;
    localparam int          FL_VIP_BIT   = 20;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RST    = 32'h0000_0002;
    localparam logic [31:0] REDIR_RST    = 32'h0000_0000;
    localparam logic [31:0] IOPM_RST     = 32'hffff_ffff;
    localparam logic [1:0]  IO_PRIVILEGE_LEVEL_MAX     = 2'h3;
    localparam logic [1:0]  V86_PRIV     = 2'h3;
    localparam logic [7:0]  GP_VECTOR    = 8'h0d;
    localparam logic [7:0]  PF_VECTOR    = 8'h0e;

    // ----------------------------------------
    // interrupt status bits
    // ----------------------------------------
    localparam int IRQ_W     = 4;
    localparam int IRQ_IO    = 0;
    localparam int IRQ_GP    = 1;
    localparam int IRQ_PF    = 2;
    localparam int IRQ_DEFER = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        KIND_EXCEPTION, KIND_NMI, KIND_EXT_HW, KIND_MASKABLE,
        KIND_SOFT_INT, KIND_SENSITIVE
    } ev_kind_t;

    typedef enum logic [1:0] {CLASS_ONE, CLASS_TWO, CLASS_THREE} ev_class_t;

    typedef enum logic [2:0] {
        ROUTE_NONE, ROUTE_PM_IDT, ROUTE_V86_HANDLER, ROUTE_GP_FAULT,
        ROUTE_DEFERRED, ROUTE_PAGE_FAULT
    } route_t;

    typedef struct packed {
        ev_kind_t   kind;
        logic [7:0] vector;
    } event_t;

    typedef struct packed {
        ev_class_t  cls;
        route_t     route;
        logic [7:0] vector;
    } dispatch_t;

endpackage

//--- v86_interrupt_io_dispatch.sv
`timescale 1ns/10ps

module v86_interrupt_io_dispatch #(
    parameter bit VME_PRESENT = 1'b1  // extension built in
) (
    input  wire logic                       core_clk,          // 50 MHz clock
    input  wire logic                       resetn,            // async reset, low
    input  wire logic [7:0]                 s_axi_awaddr,      // write address
    input  wire logic                       s_axi_awvalid,     // write address valid
    output logic                            s_axi_awready,     // write address ready
    input  wire logic [31:0]                s_axi_wdata,       // write data
    input  wire logic [3:0]                 s_axi_wstrb,       // byte strobes
    input  wire logic                       s_axi_wvalid,      // write data valid
    output logic                            s_axi_wready,      // write data ready
    output logic [1:0]                      s_axi_bresp,       // write response
    output logic                            s_axi_bvalid,      // write response valid
    input  wire logic                       s_axi_bready,      // write response ready
    input  wire logic [7:0]                 s_axi_araddr,      // read address
    input  wire logic                       s_axi_arvalid,     // read address valid
    output logic                            s_axi_arready,     // read address ready
    output logic [31:0]                     s_axi_rdata,       // read data
    output logic [1:0]                      s_axi_rresp,       // read response
    output logic                            s_axi_rvalid,      // read data valid
    input  wire logic                       s_axi_rready,      // read data ready
    input  wire logic                       ev_valid,          // event recognised
    input  wire v86_dispatch_pkg::event_t   ev,                // event kind and vector
    output logic                            disp_valid,        // decision pulse
    output v86_dispatch_pkg::dispatch_t     disp,              // class, route, vector
    input  wire logic                       io_valid,          // port access attempt
    input  wire logic [15:0]                io_port,           // port address
    output logic                            io_fault,          // port access faults
    input  wire logic                       mmio_valid,        // mapped io access
    input  wire logic                       mmio_page_present, // page present bit
    output logic                            page_fault,        // page fault pulse
    output logic                            irq                // level interrupt
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0]                     ctrl_r;
    logic [31:0]                     flags_r;
    logic [v86_dispatch_pkg::IRQ_W-1:0] istat_r;
    logic [v86_dispatch_pkg::IRQ_W-1:0] ien_r;
    logic [31:0]                     redir_mem [v86_dispatch_pkg::REDIR_WORDS];
    logic [31:0]                     iopm_mem  [v86_dispatch_pkg::IOPM_WORDS];

    // write channel capture
    logic                            aw_hold_r;
    logic                            w_hold_r;
    logic [7:0]                      awaddr_r;
    logic [31:0]                     wdata_r;
    logic [3:0]                      wstrb_r;

    // response channels
    logic                            bvalid_r;
    logic                            rvalid_r;
    logic [31:0]                     rdata_r;
    logic [1:0]                      rresp_r;

    // decision outputs
    logic                            disp_valid_r;
    v86_dispatch_pkg::dispatch_t     disp_r;
    logic                            io_fault_r;
    logic                            page_fault_r;

    // byte-lane write merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    // address inside a word window
    function automatic logic in_window(input logic [7:0] a, input logic [7:0] base,
                                       input int words);
        return (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(words * 4)));
    endfunction

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    // write fires once address and data are both held
    wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    wire do_read  = s_axi_arvalid & ~rvalid_r;
    wire wr_ctrl  = do_write & (awaddr_r == v86_dispatch_pkg::CTRL_OFS);
    wire wr_flags = do_write & (awaddr_r == v86_dispatch_pkg::FLAGS_OFS);
    wire wr_iclr  = do_write & (awaddr_r == v86_dispatch_pkg::ICLR_OFS);
    wire wr_ien   = do_write & (awaddr_r == v86_dispatch_pkg::IEN_OFS);
    wire wr_redir = do_write & in_window(awaddr_r, v86_dispatch_pkg::REDIR_BASE,
                                         v86_dispatch_pkg::REDIR_WORDS);
    wire wr_iopm  = do_write & in_window(awaddr_r, v86_dispatch_pkg::IOPM_BASE,
                                         v86_dispatch_pkg::IOPM_WORDS);
    wire wr_hit   = wr_ctrl | wr_flags | wr_iclr | wr_ien | wr_redir | wr_iopm;
    wire [2:0] wr_redir_idx = awaddr_r[4:2];
    wire [4:0] wr_iopm_idx  = awaddr_r[6:2];

    // read decode
    wire [7:0] ra = s_axi_araddr;
    wire rd_redir = in_window(ra, v86_dispatch_pkg::REDIR_BASE, v86_dispatch_pkg::REDIR_WORDS);
    wire rd_iopm  = in_window(ra, v86_dispatch_pkg::IOPM_BASE, v86_dispatch_pkg::IOPM_WORDS);
    wire rd_reg   = (ra == v86_dispatch_pkg::CTRL_OFS) | (ra == v86_dispatch_pkg::FLAGS_OFS) |
                    (ra == v86_dispatch_pkg::ISTAT_OFS) | (ra == v86_dispatch_pkg::ICLR_OFS) |
                    (ra == v86_dispatch_pkg::IEN_OFS) | (ra == v86_dispatch_pkg::LAST_OFS);
    wire rd_hit   = rd_reg | rd_redir | rd_iopm;
    wire [31:0] rd_word =
        (ra == v86_dispatch_pkg::CTRL_OFS)  ? ctrl_r :
        (ra == v86_dispatch_pkg::FLAGS_OFS) ? flags_r :
        (ra == v86_dispatch_pkg::ISTAT_OFS) ? {28'h0, istat_r} :
        (ra == v86_dispatch_pkg::IEN_OFS)   ? {28'h0, ien_r} :
        (ra == v86_dispatch_pkg::LAST_OFS)  ? {19'h0, disp_r} :
        rd_redir ? redir_mem[ra[4:2]] :
        rd_iopm  ? iopm_mem[ra[6:2]] : 32'h0000_0000;

    assign s_axi_awready = ~aw_hold_r;
    assign s_axi_wready  = ~w_hold_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    logic [1:0] bresp_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= v86_dispatch_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end

            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end

            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? v86_dispatch_pkg::RESP_OKAY : v86_dispatch_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= v86_dispatch_pkg::RESP_OKAY;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? v86_dispatch_pkg::RESP_OKAY : v86_dispatch_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // mode and flag decode
    // ----------------------------------------
    wire       vme_on   = VME_PRESENT & ctrl_r[v86_dispatch_pkg::CTRL_VME_BIT];
    wire       vm       = flags_r[v86_dispatch_pkg::FL_VM_BIT];
    wire [1:0] io_privilege_level     = flags_r[v86_dispatch_pkg::FL_IO_PRIVILEGE_LEVEL_LSB +: 2];
    wire [1:0] current_privilege      = vm ? v86_dispatch_pkg::V86_PRIV
                             : ctrl_r[v86_dispatch_pkg::CTRL_PL_LSB +: 2];
    wire       virtual_int_flag      = VME_PRESENT & flags_r[v86_dispatch_pkg::FL_VIF_BIT];
    wire       virt_on  = vme_on & vm & (io_privilege_level != v86_dispatch_pkg::IO_PRIVILEGE_LEVEL_MAX);
    wire       redir_bit = redir_mem[ev.vector[7:5]][ev.vector[4:0]];

    // ----------------------------------------
    // event classification and routing
    // ----------------------------------------
    wire is_soft  = ev.kind == v86_dispatch_pkg::KIND_SOFT_INT;
    wire is_mask  = ev.kind == v86_dispatch_pkg::KIND_MASKABLE;
    wire is_sens  = ev.kind == v86_dispatch_pkg::KIND_SENSITIVE;
    wire class2   = is_mask & vme_on & vm;
    v86_dispatch_pkg::ev_class_t cls_w;
    assign cls_w = is_soft ? v86_dispatch_pkg::CLASS_THREE :
                   class2  ? v86_dispatch_pkg::CLASS_TWO :
                             v86_dispatch_pkg::CLASS_ONE;

    // sensitive insns fault in v86 mode below io level 3
    wire sens_fault = vm & (io_privilege_level < v86_dispatch_pkg::IO_PRIVILEGE_LEVEL_MAX);
    v86_dispatch_pkg::route_t c1_route;
    v86_dispatch_pkg::route_t c2_route;
    v86_dispatch_pkg::route_t c3_route;
    v86_dispatch_pkg::route_t route_w;
    assign c1_route = !is_sens  ? v86_dispatch_pkg::ROUTE_PM_IDT :
                      sens_fault ? v86_dispatch_pkg::ROUTE_GP_FAULT :
                                   v86_dispatch_pkg::ROUTE_NONE;
    assign c2_route = (!virt_on || virtual_int_flag) ? v86_dispatch_pkg::ROUTE_PM_IDT :
                                          v86_dispatch_pkg::ROUTE_DEFERRED;

    // class three: redirect, then io level
    assign c3_route = !vm ? v86_dispatch_pkg::ROUTE_PM_IDT :
                      (vme_on && !redir_bit) ? v86_dispatch_pkg::ROUTE_V86_HANDLER :
                      (io_privilege_level == v86_dispatch_pkg::IO_PRIVILEGE_LEVEL_MAX) ? v86_dispatch_pkg::ROUTE_PM_IDT :
                      v86_dispatch_pkg::ROUTE_GP_FAULT;
    assign route_w = (cls_w == v86_dispatch_pkg::CLASS_THREE) ? c3_route :
                     (cls_w == v86_dispatch_pkg::CLASS_TWO)   ? c2_route : c1_route;

    wire [7:0] vec_w = (route_w == v86_dispatch_pkg::ROUTE_GP_FAULT) ?
                       v86_dispatch_pkg::GP_VECTOR : ev.vector;
    v86_dispatch_pkg::dispatch_t disp_w;
    assign disp_w = '{cls: cls_w, route: route_w, vector: vec_w};

    // status events from this decision
    wire ev_gp    = ev_valid & (route_w == v86_dispatch_pkg::ROUTE_GP_FAULT);
    wire ev_defer = ev_valid & (route_w == v86_dispatch_pkg::ROUTE_DEFERRED);

    // ----------------------------------------
    // port and mapped io checks
    // ----------------------------------------
    wire port_in_map = {1'b0, io_port} < v86_dispatch_pkg::IOPM_PORTS;
    wire port_prot   = ~port_in_map | iopm_mem[io_port[9:5]][io_port[4:0]];
    wire io_bypass   = ~vm & (current_privilege <= io_privilege_level);
    wire io_fault_w  = io_valid & port_prot & ~io_bypass;
    wire pf_w        = mmio_valid & ~mmio_page_present;

    // ----------------------------------------
    // decisions, registered once per event
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            disp_valid_r <= 1'b0;
            disp_r       <= '{cls: v86_dispatch_pkg::CLASS_ONE,
                              route: v86_dispatch_pkg::ROUTE_NONE, vector: 8'h00};
            io_fault_r   <= 1'b0;
            page_fault_r <= 1'b0;
        end else begin
            disp_valid_r <= ev_valid;
            if (ev_valid) begin
                disp_r <= disp_w;
            end

            io_fault_r   <= io_fault_w;
            page_fault_r <= pf_w;
        end
    end

    assign disp_valid = disp_valid_r;
    assign disp       = disp_r;
    assign io_fault   = io_fault_r;
    assign page_fault = page_fault_r;

    // ----------------------------------------
    // software registers and bitmaps
    // ----------------------------------------
    logic [v86_dispatch_pkg::IRQ_W-1:0] ev_set;
    assign ev_set = {ev_defer, pf_w, ev_gp, io_fault_w};
    wire [v86_dispatch_pkg::IRQ_W-1:0] iclr_bits = wr_iclr ?
        wdata_r[v86_dispatch_pkg::IRQ_W-1:0] : '0;
    // hardware sets pending over a software write
    wire [31:0] flags_sw  = wr_flags ? merge(flags_r, wdata_r, wstrb_r) : flags_r;
    wire [31:0] flags_nxt = flags_sw | (32'(ev_defer) << v86_dispatch_pkg::FL_VIP_BIT);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r  <= v86_dispatch_pkg::CTRL_RST;
            flags_r <= v86_dispatch_pkg::FLAGS_RST;
            istat_r <= '0;
            ien_r   <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
            end

            flags_r <= flags_nxt;
            // status set wins over clear
            istat_r <= (istat_r & ~iclr_bits) | ev_set;

            if (wr_ien) begin
                ien_r <= wdata_r[v86_dispatch_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < v86_dispatch_pkg::REDIR_WORDS; i++) begin
                redir_mem[i] <= v86_dispatch_pkg::REDIR_RST;
            end
            for (int i = 0; i < v86_dispatch_pkg::IOPM_WORDS; i++) begin
                iopm_mem[i] <= v86_dispatch_pkg::IOPM_RST;
            end
        end else begin
            if (wr_redir) begin
                redir_mem[wr_redir_idx] <= merge(redir_mem[wr_redir_idx], wdata_r, wstrb_r);
            end

            if (wr_iopm) begin
                iopm_mem[wr_iopm_idx] <= merge(iopm_mem[wr_iopm_idx], wdata_r, wstrb_r);
            end
        end
    end

    // level interrupt from enabled status
    assign irq = |(istat_r & ien_r);

endmodule // v86_interrupt_io_dispatch

//--- v86_dispatch_monitor.sv
`timescale 1ns/10ps
module v86_dispatch_monitor (
    input wire logic                        core_clk,          // clock
    input wire logic                        resetn,            // reset, low
    input wire logic                        ev_valid,          // event in
    input wire v86_dispatch_pkg::event_t    ev,                // event
    input wire logic                        disp_valid,        // decision pulse
    input wire v86_dispatch_pkg::dispatch_t disp,              // decision
    input wire logic                        io_valid,          // port access
    input wire logic                        io_fault,          // port fault
    input wire logic                        mmio_valid,        // mapped access
    input wire logic                        mmio_page_present, // page present
    input wire logic                        page_fault         // page fault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_lat; ev_valid |=> disp_valid; endproperty
    a_lat: assert property (p_lat) else $error("decision pulse missing");
    property p_quiet; !ev_valid |=> !disp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("decision without event");
    property p_hw; ev_valid && ev.kind < v86_dispatch_pkg::KIND_MASKABLE |=> disp.cls == v86_dispatch_pkg::CLASS_ONE
        && disp.route == v86_dispatch_pkg::ROUTE_PM_IDT && disp.vector == $past(ev.vector); endproperty
    a_hw: assert property (p_hw) else $error("hardware event misrouted");
    property p_soft; ev_valid && ev.kind == v86_dispatch_pkg::KIND_SOFT_INT
        |=> disp.cls == v86_dispatch_pkg::CLASS_THREE; endproperty
    a_soft: assert property (p_soft) else $error("software interrupt class wrong");
    property p_gp; disp_valid && disp.route == v86_dispatch_pkg::ROUTE_GP_FAULT |-> disp.vector == 8'h0d; endproperty
    a_gp: assert property (p_gp) else $error("gp route with wrong vector");
    property p_defer; disp_valid && disp.route == v86_dispatch_pkg::ROUTE_DEFERRED
        |-> disp.cls == v86_dispatch_pkg::CLASS_TWO; endproperty
    a_defer: assert property (p_defer) else $error("deferral outside class two");
    property p_page; mmio_valid && !mmio_page_present |=> page_fault; endproperty
    a_page: assert property (p_page) else $error("page fault missing");
    property p_io; !io_valid |=> !io_fault; endproperty
    a_io: assert property (p_io) else $error("port fault without access");
endmodule // v86_dispatch_monitor
bind v86_interrupt_io_dispatch v86_dispatch_monitor i_v86_dispatch_monitor (.core_clk, .resetn, .ev_valid, .ev,
    .disp_valid, .disp, .io_valid, .io_fault, .mmio_valid, .mmio_page_present, .page_fault);

//--- io_event_source.sv
`timescale 1ns/10ps
module io_event_source (
    input wire logic                        core_clk,          // clock
    input wire logic                        disp_valid,        // decision pulse
    input wire v86_dispatch_pkg::dispatch_t disp,              // decision
    input wire logic                        io_fault,          // port fault
    input wire logic                        page_fault,        // page fault
    output v86_dispatch_pkg::event_t        ev,                // event
    output logic                            ev_valid,          // event strobe
    output logic [15:0]                     io_port,           // port address
    output logic                            io_valid,          // port strobe
    output logic                            mmio_valid,        // mapped strobe
    output logic                            mmio_page_present  // page present
);
    initial begin
        ev = '0;
        ev_valid = 1'b0;
        io_port = 16'h0000;
        io_valid = 1'b0;
        mmio_valid = 1'b0;
        mmio_page_present = 1'b1;
    end
    // idle payloads flip so stale values never match
    task automatic send_ev(input v86_dispatch_pkg::event_t e, output logic ok, output v86_dispatch_pkg::dispatch_t d);
        @(posedge core_clk);
        ev_valid <= 1'b1;
        ev <= e;
        @(posedge core_clk);
        ev_valid <= 1'b0;
        ev <= ~e;
        #1;
        ok = disp_valid;
        d = disp;
    endtask
    task automatic send_io(input logic [15:0] p, input logic m, input logic pr, output logic f);
        @(posedge core_clk);
        io_valid <= ~m;
        mmio_valid <= m;
        io_port <= p;
        mmio_page_present <= pr;
        @(posedge core_clk);
        io_valid <= 1'b0;
        mmio_valid <= 1'b0;
        io_port <= ~p;
        mmio_page_present <= ~pr;
        #1;
        f = m ? page_fault : io_fault;
    endtask
endmodule // io_event_source

//--- tb.sv
`timescale 1ns/10ps
module tb;
    logic        core_clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, disp_valid, io_fault, page_fault, irq;
    logic        ev_valid, io_valid, mmio_valid, mmio_pres;
    logic [15:0] io_port;
    v86_dispatch_pkg::event_t    ev;
    v86_dispatch_pkg::dispatch_t disp;
    int          fail_count = 0, compares = 0, cycles = 0;
    v86_interrupt_io_dispatch i_v86_interrupt_io_dispatch (.core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ev_valid(ev_valid), .ev(ev), .disp_valid(disp_valid), .disp(disp),
        .io_valid(io_valid), .io_port(io_port), .io_fault(io_fault), .mmio_valid(mmio_valid),
        .mmio_page_present(mmio_pres), .page_fault(page_fault), .irq(irq));
    io_event_source i_io_event_source (.core_clk(core_clk), .disp_valid(disp_valid), .disp(disp),
        .io_fault(io_fault), .page_fault(page_fault), .ev(ev), .ev_valid(ev_valid), .io_port(io_port),
        .io_valid(io_valid), .mmio_valid(mmio_valid), .mmio_page_present(mmio_pres));
    always #10 core_clk = ~core_clk;
    task automatic tally_and_finish;
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] fl(input logic vm, input logic [1:0] pl, input logic virtual_int_flag);
        fl = {12'h000, virtual_int_flag, 1'b0, vm, 3'h0, pl, 12'h002};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tk, aw = 1'b0, w = 1'b0;
        logic [1:0] r;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            aw |= ta;
            w |= tw;
        end
        do begin
            @(negedge core_clk);
            tk = bvalid;
            r = bresp;
            @(posedge core_clk);
        end while (!tk);
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic tk;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge core_clk);
            tk = arready;
            @(posedge core_clk);
        end while (!tk);
        arvalid <= 1'b0;
        do begin
            @(negedge core_clk);
            tk = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
        end while (!tk);
        rready <= 1'b0;
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask
    // kind, vector, expected {class, route, vector}
    task automatic ek(input logic [2:0] k, input logic [7:0] v, input logic [12:0] e);
        logic ok;
        v86_dispatch_pkg::dispatch_t d;
        i_io_event_source.send_ev({k, v}, ok, d);
        chk({31'h0, ok}, 32'h1);
        chk({19'h0, d}, {19'h0, e});
    endtask
    task automatic io(input logic [15:0] p, input logic m, input logic pr, input logic ef);
        logic f;
        i_io_event_source.send_io(p, m, pr, f);
        chk({31'h0, f}, {31'h0, ef});
    endtask
    initial begin
        logic ok;
        v86_dispatch_pkg::dispatch_t d;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h2, 2'h0);
        rd(8'h80, 32'hffffffff, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h04, fl(1'b1, 2'h3, 1'b0), 2'h0);
        io(16'h0005, 1'b0, 1'b1, 1'b1);
        wr(8'h80, 32'h0, 2'h0);
        io(16'h0005, 1'b0, 1'b1, 1'b0);
        io(16'h0400, 1'b0, 1'b1, 1'b1);
        ek(3'h0, 8'h06, {2'h0, 3'h1, 8'h06});
        ek(3'h1, 8'h02, {2'h0, 3'h1, 8'h02});
        ek(3'h2, 8'h20, {2'h0, 3'h1, 8'h20});
        ek(3'h4, 8'h21, {2'h2, 3'h2, 8'h21});
        wr(8'h44, 32'h2, 2'h0);
        ek(3'h4, 8'h21, {2'h2, 3'h1, 8'h21});
        wr(8'h04, fl(1'b1, 2'h0, 1'b0), 2'h0);
        ek(3'h4, 8'h21, {2'h2, 3'h3, 8'h0d});
        i_io_event_source.send_ev({3'h5, 8'h00}, ok, d);
        chk({29'h0, d.route}, 32'h3);
        ek(3'h3, 8'h30, {2'h1, 3'h4, 8'h30});
        rd(8'h04, fl(1'b1, 2'h0, 1'b0) | 32'h00100000, 2'h0);
        wr(8'h04, fl(1'b1, 2'h0, 1'b1), 2'h0);
        ek(3'h3, 8'h30, {2'h1, 3'h1, 8'h30});
        wr(8'h00, 32'h0, 2'h0);
        ek(3'h3, 8'h30, {2'h0, 3'h1, 8'h30});
        wr(8'h04, fl(1'b0, 2'h3, 1'b0), 2'h0);
        ek(3'h4, 8'h21, {2'h2, 3'h1, 8'h21});
        wr(8'h00, 32'h30, 2'h0);
        io(16'h0020, 1'b0, 1'b1, 1'b0);
        wr(8'h04, fl(1'b0, 2'h2, 1'b0), 2'h0);
        io(16'h0020, 1'b0, 1'b1, 1'b1);
        io(16'h0000, 1'b1, 1'b0, 1'b1);
        io(16'h0000, 1'b1, 1'b1, 1'b0);
        rd(8'h08, 32'hf, 2'h0);
        wr(8'h10, 32'h2, 2'h0);
        chk({31'h0, irq}, 32'h1);
        wr(8'h0c, 32'h2, 2'h0);
        chk({31'h0, irq}, 32'h0);
        rd(8'h08, 32'hd, 2'h0);
        wr(8'h08, 32'h0, 2'h2);
        rd(8'h14, 32'h1121, 2'h0);
        tally_and_finish;
    end
endmodule // tb
